/* testbench/ead_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ead_core_chk (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_video_resetn,
	input wire logic i_video_clk_en,
	input wire logic i_reg_port_clk_en,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rd_resp,
	input wire logic o_wr_ack,
	input wire logic [1:0] o_wr_resp,
	input wire logic o_s_axis_tready,
	input wire logic [7:0] o_m_axis_tdata,
	input wire logic o_m_axis_tvalid,
	input wire logic o_m_axis_tuser,
	input wire logic i_m_axis_tready
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	logic ctrl_reg;
	logic [7:0] stall_reg;
	wire logic core_a = (i_addr == 12'h008) || (i_addr == 12'h020) || (i_addr == 12'h100);
	wire logic rd_go = i_rd && i_reg_port_clk_en;
	wire logic wr_go = i_wr && i_reg_port_clk_en;
	// Shadow of the run bit and the stalled-clock count, so timeouts are predicted from ports alone
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= 1'b1;
			stall_reg <= 8'h00;
		end else begin
			if (wr_go && i_addr == 12'h000)
				ctrl_reg <= i_wdata[0];
			if (i_video_clk_en && i_video_resetn && ctrl_reg)
				stall_reg <= 8'h00;
			else if (stall_reg != 8'h80)
				stall_reg <= stall_reg + 8'h01;
		end
	end
	property p_wr_ack; wr_go |=> o_wr_ack; endproperty
	property p_no_ack; !wr_go |=> !o_wr_ack; endproperty
	property p_rd_idle; !rd_go |=> o_rdata == 32'h0 && o_rd_resp == 2'h0; endproperty
	property p_rd_tmo; rd_go && core_a && stall_reg == 8'h80 |=> o_rd_resp == 2'h2 && o_rdata == 32'h0; endproperty
	property p_wr_tmo; wr_go && core_a && stall_reg == 8'h80 |=> o_wr_ack && o_wr_resp == 2'h2; endproperty
	property p_rd_ok; rd_go && stall_reg < 8'h80 |=> o_rd_resp == 2'h0; endproperty
	property p_freeze; !i_video_clk_en && i_video_resetn && o_m_axis_tvalid |=> o_m_axis_tvalid && $stable(o_m_axis_tdata);
	endproperty
	property p_hold; o_m_axis_tvalid && !i_m_axis_tready && i_video_resetn |=> o_m_axis_tvalid && $stable(o_m_axis_tdata);
	endproperty
	property p_vrst; !i_video_resetn |=> !o_m_axis_tvalid && !o_s_axis_tready; endproperty
	property p_rdy_frz; !i_video_clk_en && i_video_resetn |=> $stable(o_s_axis_tready); endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");
	a_no_ack: assert property (p_no_ack) else $error("acknowledge without accepted write");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	a_rd_tmo: assert property (p_rd_tmo) else $error("stalled core read not answered with 10");
	a_wr_tmo: assert property (p_wr_tmo) else $error("stalled core write not answered with 10");
	a_rd_ok: assert property (p_rd_ok) else $error("reachable read answered with error");
	a_freeze: assert property (p_freeze) else $error("output moved while video enable low");
	a_hold: assert property (p_hold) else $error("output beat changed before taken");
	a_vrst: assert property (p_vrst) else $error("video reset left stream active");
	a_rdy_frz: assert property (p_rdy_frz) else $error("input ready moved while frozen");
	c_tmo: cover property (rd_go && core_a && stall_reg == 8'h80);
	c_sof: cover property (o_m_axis_tvalid && i_m_axis_tready && o_m_axis_tuser);
	c_frz: cover property (!i_video_clk_en && o_m_axis_tvalid);
endmodule // ead_core_chk
bind ead_core ead_core_chk ead_core_chk_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_video_resetn(i_video_resetn),
	.i_video_clk_en(i_video_clk_en), .i_reg_port_clk_en(i_reg_port_clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_resp(o_rd_resp), .o_wr_ack(o_wr_ack), .o_wr_resp(o_wr_resp),
	.o_s_axis_tready(o_s_axis_tready), .o_m_axis_tdata(o_m_axis_tdata), .o_m_axis_tvalid(o_m_axis_tvalid),
	.o_m_axis_tuser(o_m_axis_tuser), .i_m_axis_tready(i_m_axis_tready));
`default_nettype wire

/* testbench/ead_stream_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ead_stream_peer (
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_start,
	input wire logic i_sof,
	input wire logic [7:0] i_count,
	input wire logic [7:0] i_line,
	input wire logic i_stall,
	input wire logic i_tready,
	output logic [7:0] o_tdata = 8'h00,
	output logic o_tvalid = 1'b0,
	output logic o_tuser = 1'b0,
	output logic o_tlast = 1'b0,
	output logic o_ready = 1'b1,
	output wire logic o_done
);
	logic [7:0] idx_reg = 8'h00;
	// Source holds each beat until taken under the shared enable
	always @(posedge i_clock) begin
		if (i_start) begin
			idx_reg <= 8'h00;
			o_tvalid <= 1'b1;
			o_tuser <= i_sof;
			o_tlast <= (i_line == 8'h01);
			o_tdata <= 8'h00;
		end else if (o_tvalid && i_clk_en && i_tready) begin
			idx_reg <= idx_reg + 8'h01;
			o_tvalid <= (idx_reg + 8'h01 != i_count);
			o_tuser <= 1'b0;
			o_tlast <= ((idx_reg + 8'h02) % i_line == 8'h00);
			// Released data flips so a stale value never looks valid
			o_tdata <= (idx_reg + 8'h01 == i_count) ? ~o_tdata : idx_reg + 8'h01;
		end
		// Sink stalls every other cycle on request
		o_ready <= !i_stall || !o_ready;
	end
	assign o_done = !o_tvalid;
endmodule // ead_stream_peer
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ead_map.vh"
module tb_top;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic i_video_resetn = 1'b1;
	logic i_video_clk_en = 1'b1;
	logic i_reg_port_clk_en = 1'b1;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic st_go = 1'b0;
	logic st_sof = 1'b0;
	logic st_stall = 1'b1;
	logic [7:0] st_cnt = 8'h00;
	logic [7:0] st_line = 8'h01;
	logic pix_chk = 1'b1;
	wire logic [31:0] o_rdata;
	wire logic [1:0] o_rd_resp, o_wr_resp;
	wire logic o_wr_ack, s_ready, s_valid, s_user, s_last, st_done;
	wire logic [7:0] s_data, o_m_axis_tdata;
	wire logic o_m_axis_tvalid, o_m_axis_tuser, o_m_axis_tlast, m_ready;
	int checks = 0;
	int num_errors = 0;
	int out_cnt, user_cnt, last_cnt;
	logic [31:0] exp_pix;
	always #25 i_clock = ~i_clock;
	ead_core ead_core_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_video_resetn(i_video_resetn),
		.i_video_clk_en(i_video_clk_en), .i_reg_port_clk_en(i_reg_port_clk_en), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_resp(o_rd_resp), .o_wr_ack(o_wr_ack), .o_wr_resp(o_wr_resp),
		.i_s_axis_tdata(s_data), .i_s_axis_tvalid(s_valid), .i_s_axis_tuser(s_user), .i_s_axis_tlast(s_last),
		.o_s_axis_tready(s_ready), .o_m_axis_tdata(o_m_axis_tdata), .o_m_axis_tvalid(o_m_axis_tvalid),
		.o_m_axis_tuser(o_m_axis_tuser), .o_m_axis_tlast(o_m_axis_tlast), .i_m_axis_tready(m_ready));
	ead_stream_peer ead_stream_peer_i (.i_clock(i_clock), .i_clk_en(i_video_clk_en), .i_start(st_go), .i_sof(st_sof),
		.i_count(st_cnt), .i_line(st_line), .i_stall(st_stall), .i_tready(s_ready), .o_tdata(s_data),
		.o_tvalid(s_valid), .o_tuser(s_user), .o_tlast(s_last), .o_ready(m_ready), .o_done(st_done));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Register bus cycles; answer sampled once the answer edge has landed
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
		chk("wr_ack", {29'h0, o_wr_ack, o_wr_resp}, {29'h0, i_reg_port_clk_en, resp});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk("rdata", o_rdata, d);
		chk("rd_resp", {30'h0, o_rd_resp}, {30'h0, resp});
	endtask
	task automatic go(input logic s, input logic [7:0] n, input logic [7:0] ln);
		out_cnt = 0;
		user_cnt = 0;
		last_cnt = 0;
		exp_pix = 32'h0;
		@(posedge i_clock);
		st_sof <= s;
		st_cnt <= n;
		st_line <= ln;
		st_go <= 1'b1;
		@(posedge i_clock);
		st_go <= 1'b0;
		#1;
	endtask
	task automatic fin(input int n);
		int k;
		k = 0;
		while ((!st_done || out_cnt != n) && k < 400) begin
			@(posedge i_clock);
			k++;
		end
		#1;
		chk("out_beats", out_cnt, n);
		chk("src_done", {31'h0, st_done}, 32'h1);
		if (k == 400 && num_errors != 0)
			finish_test();
	endtask
	// Frame outcome: beat count, markers, then error flags read and cleared
	task automatic frame(input int n, input logic [31:0] u, input logic [31:0] l, input logic [31:0] e);
		fin(n);
		chk("sof_out", out_cnt == 0 ? 32'h0 : user_cnt, u);
		chk("eol_out", last_cnt, l);
		rd(`EAD_ERR_OFF, e, 2'h0);
		wr(`EAD_ERR_OFF, 32'hF, 2'h0);
	endtask
	// Output monitor; bypass makes each pixel equal its input
	always @(posedge i_clock) begin
		if (o_m_axis_tvalid && m_ready && i_video_clk_en && i_video_resetn) begin
			out_cnt++;
			user_cnt += o_m_axis_tuser;
			last_cnt += o_m_axis_tlast;
			if (pix_chk)
				chk("pixel", {24'h0, o_m_axis_tdata}, exp_pix);
			exp_pix++;
		end
	end
	initial begin
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(`EAD_CTRL_OFF, `EAD_CTRL_RST, 2'h0);
		rd(`EAD_STAT_OFF, 32'h5, 2'h0);
		rd(`EAD_SIZE_OFF, `EAD_SIZE_RST, 2'h0);
		rd(`EAD_STRENGTH_OFF, {29'h0, `EAD_STRENGTH_RST}, 2'h0);
		rd(12'h0FC, 32'h0, 2'h0);
		// Quiet the core before reprogramming it, re-enable after
		wr(`EAD_CTRL_OFF, 32'h0, 2'h0);
		rd(`EAD_CTRL_OFF, 32'h0, 2'h0);
		wr(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		rd(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		wr(`EAD_CTRL_OFF, 32'h1, 2'h0);
		for (int s = 1; s <= 4; s++) begin
			wr(`EAD_STRENGTH_OFF, s, 2'h0);
			rd(`EAD_STRENGTH_OFF, s, 2'h0);
		end
		wr(`EAD_STRENGTH_OFF, 32'h5, 2'h0);
		rd(`EAD_STRENGTH_OFF, 32'h4, 2'h0);
		wr(`EAD_STRENGTH_OFF, 32'h0, 2'h0);
		$display("test registers done");
		// Stream with register port off and a stalling sink
		i_reg_port_clk_en <= 1'b0;
		wr(`EAD_SIZE_OFF, 32'h0003_0003, 2'h0);
		go(1'b1, 8'd8, 8'd4);
		i_reg_port_clk_en <= 1'b1;
		frame(8, 1, 2, 32'h0);
		rd(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		go(1'b1, 8'd6, 8'd3);
		frame(6, 1, 2, 32'h1);
		pix_chk = 1'b0;
		go(1'b1, 8'd10, 8'd5);
		frame(8, 1, 2, 32'h2);
		pix_chk = 1'b1;
		go(1'b1, 8'd3, 8'd255);
		fin(3);
		go(1'b1, 8'd8, 8'd4);
		frame(8, 1, 2, 32'h4);
		go(1'b1, 8'd8, 8'd4);
		fin(8);
		go(1'b0, 8'd4, 8'd4);
		frame(0, 0, 0, 32'h8);
		// Strongest filter still keeps beat and marker counts
		wr(`EAD_STRENGTH_OFF, 32'h4, 2'h0);
		pix_chk = 1'b0;
		go(1'b1, 8'd8, 8'd4);
		frame(8, 1, 2, 32'h0);
		pix_chk = 1'b1;
		wr(`EAD_STRENGTH_OFF, 32'h0, 2'h0);
		$display("test framing done");
		// Freeze mid-frame; core registers time out only after 128 stalled clocks
		go(1'b1, 8'd8, 8'd4);
		repeat (3) @(posedge i_clock);
		i_video_clk_en <= 1'b0;
		repeat (120) @(posedge i_clock);
		rd(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		repeat (10) @(posedge i_clock);
		rd(`EAD_SIZE_OFF, 32'h0, 2'h2);
		wr(`EAD_SIZE_OFF, 32'h0003_0003, 2'h2);
		rd(`EAD_STAT_OFF, 32'h2, 2'h0);
		rd(`EAD_CTRL_OFF, 32'h1, 2'h0);
		i_video_clk_en <= 1'b1;
		rd(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		frame(8, 1, 2, 32'h0);
		$display("test freeze done");
		// Video reset keeps registers; full reset restores them
		i_video_resetn <= 1'b0;
		rd(`EAD_SIZE_OFF, 32'h0002_0004, 2'h0);
		chk("in_ready", {31'h0, s_ready}, 32'h0);
		repeat (30) @(posedge i_clock);
		i_video_resetn <= 1'b1;
		go(1'b1, 8'd8, 8'd4);
		frame(8, 1, 2, 32'h0);
		i_resetn <= 1'b0;
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(`EAD_SIZE_OFF, `EAD_SIZE_RST, 2'h0);
		$display("test resets done");
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

/* verilog/ead_core.v */
// What this block does
// - Smoothing gain falls near edges so edges are smoothed less.
// - Four smoothing strengths of rising effect plus a bypass.
// - Strength register at 0x100 takes 0..4; 0 bypasses, 4 strongest.
// - Output frame size, pixel rate and frame rate follow the input.
// - Input and output streams share the one video clock.
// - Register transactions always complete even while video is stalled.
// - Video clock enable low freezes video logic, not frame aligned.
// - Register port enable low stops only the register port.
// - Video reset clears only streaming side; mid-frame use tears.
// - Register port reset clears the core except the line buffers, both streams included.
// - Core access stuck over 128 clocks ends with an error response.
// - Timed-out read and write both answer response code 10.
// - Core registers unreachable while video reset or enable held low.
// - Configured size predicts line ends and frame starts; misses are errors.
// - Size register: pixels per line bits 12:0, lines bits 28:16.
// - Early input start of frame starts output frame at once.
// - Late start of frame: frame ends as programmed, surplus dropped.
// - Early input line end ends output line at once.
// - Late line end: line ends as programmed, surplus pixels dropped.
// - Without register port, fixed configuration and clock enable only.
`timescale 1ns/1ps
`default_nettype none
`include "ead_map.vh"
module ead_core #(
	parameter HAS_REG_PORT = 1
) (
	input wire i_clock,
	input wire i_resetn,
	input wire i_video_resetn,
	input wire i_video_clk_en,
	input wire i_reg_port_clk_en,
	input wire [11:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rd_resp,
	output reg o_wr_ack,
	output reg [1:0] o_wr_resp,
	input wire [7:0] i_s_axis_tdata,
	input wire i_s_axis_tvalid,
	input wire i_s_axis_tuser,
	input wire i_s_axis_tlast,
	output reg o_s_axis_tready,
	output reg [7:0] o_m_axis_tdata,
	output reg o_m_axis_tvalid,
	output reg o_m_axis_tuser,
	output reg o_m_axis_tlast,
	input wire i_m_axis_tready
);

	// True for registers held on the video side
	function ead_is_core;
		input [11:0] a;
		begin
			ead_is_core = (a == `EAD_ERR_OFF) || (a == `EAD_SIZE_OFF) || (a == `EAD_STRENGTH_OFF);
		end
	endfunction

	reg [31:0] ctrl_reg;
	reg [31:0] size_reg;
	reg [2:0] strength_reg;
	reg [3:0] err_reg;
	reg [3:0] err_next;
	reg [7:0] stall_cnt_reg;
	reg [12:0] x_reg;
	reg [12:0] y_reg;
	reg [12:0] x_next;
	reg [12:0] y_next;
	reg expect_sof_reg;
	reg expect_sof_next;
	reg drop_line_reg;
	reg drop_line_next;
	reg drop_frame_reg;
	reg drop_frame_next;
	reg [12:0] cx;
	reg [12:0] cy;
	reg emit;
	reg e_sof;
	reg e_eol;
	reg [3:0] ev;
	reg [7:0] lb1 [0:7679];
	reg [7:0] lb2 [0:7679];
	reg [7:0] left_reg;
	reg [7:0] center_reg;
	reg [7:0] up_reg;
	reg [7:0] down_reg;
	reg [7:0] skid_data_reg;
	reg skid_user_reg;
	reg skid_last_reg;
	reg skid_valid_reg;
	wire [12:0] width;
	wire [12:0] height;
	wire run;
	wire in_fire;
	wire out_take;
	wire unreachable;
	wire wr_en;
	wire rd_en;
	wire lb_ok;
	wire [7:0] right_tap;
	wire [7:0] up_tap;
	wire [7:0] filt_pixel;
	wire [7:0] new_pixel;
	// Frame geometry from the size register
	assign width = size_reg[`EAD_PIX_MSB:`EAD_PIX_LSB];
	assign height = size_reg[`EAD_LIN_MSB:`EAD_LIN_LSB];
	// Video side runs only with its enable high and its reset released
	// Without a register port the software run bit drops out
	assign run = i_video_clk_en && i_video_resetn && (ctrl_reg[`EAD_CTRL_RUN] || (HAS_REG_PORT == 0));
	// Both stream handshakes count on the same clock and the same run
	assign in_fire = i_s_axis_tvalid && o_s_axis_tready && run;
	assign out_take = o_m_axis_tvalid && i_m_axis_tready && run;
	// Register port gated only by its own enable, never by video state
	assign wr_en = i_wr && i_reg_port_clk_en && (HAS_REG_PORT != 0);
	assign rd_en = i_rd && i_reg_port_clk_en && (HAS_REG_PORT != 0);
	// Core registers count as unreachable after 128 stalled clocks
	assign unreachable = (stall_cnt_reg == `EAD_TIMEOUT_CYC);
	// Framing recovery: predict line ends and frame starts
	always @* begin
		x_next = x_reg;
		y_next = y_reg;
		expect_sof_next = expect_sof_reg;
		drop_line_next = drop_line_reg;
		drop_frame_next = drop_frame_reg;
		cx = x_reg;
		cy = y_reg;
		emit = 1'b0;
		e_sof = 1'b0;
		e_eol = 1'b0;
		ev = 4'h0;
		if (in_fire) begin
			if (i_s_axis_tuser) begin
				// Start seen while not expected is early; restart at once
				ev[`EAD_ERR_SOF_EARLY] = !expect_sof_reg && !drop_frame_reg;
				cx = 13'h0000;
				cy = 13'h0000;
				drop_line_next = 1'b0;
				drop_frame_next = 1'b0;
				expect_sof_next = 1'b0;
				emit = 1'b1;
			end else if (drop_frame_reg) begin
				emit = 1'b0; // Surplus of the old frame
			end else if (drop_line_reg) begin
				// Surplus pixels until the input line end
				if (i_s_axis_tlast) begin
					drop_line_next = 1'b0;
				end
			end else if (expect_sof_reg) begin
				// Frame already ended as programmed; drop until start
				ev[`EAD_ERR_SOF_LATE] = 1'b1;
				expect_sof_next = 1'b0;
				drop_frame_next = 1'b1;
			end else begin
				emit = 1'b1;
			end
			if (emit) begin
				e_sof = (cx == 13'h0000) && (cy == 13'h0000);
				e_eol = (cx == width - 13'h0001) || i_s_axis_tlast;
				// Input line end before the programmed width
				ev[`EAD_ERR_EOL_EARLY] = i_s_axis_tlast && (cx != width - 13'h0001);
				if ((cx == width - 13'h0001) && !i_s_axis_tlast) begin
					ev[`EAD_ERR_EOL_LATE] = 1'b1; // Line closed here
					drop_line_next = 1'b1;
				end
				if (e_eol) begin
					x_next = 13'h0000;
					if (cy == height - 13'h0001) begin
						y_next = 13'h0000;
						expect_sof_next = 1'b1;
					end else begin
						y_next = cy + 13'h0001;
					end
				end else begin
					x_next = cx + 13'h0001;
					y_next = cy;
				end
			end
		end
	end

	// Sticky errors: a new event beats a clear in the same cycle
	always @* begin
		err_next = err_reg;
		if (wr_en && (i_addr == `EAD_ERR_OFF) && !unreachable) begin
			err_next = err_next & ~i_wdata[3:0];
		end
		err_next = err_next | ev;
	end

	// Line buffer taps; index guarded against an oversized width
	assign lb_ok = (cx < `EAD_MAX_PIX);
	assign right_tap = lb_ok ? lb1[cx] : 8'h00;
	assign up_tap = lb_ok ? lb2[cx] : 8'h00;
	ead_kernel u_kernel (
		.i_left(left_reg),
		.i_right(right_tap),
		.i_up(up_reg),
		.i_down(down_reg),
		.i_center(center_reg),
		.i_strength(strength_reg),
		.o_pixel(filt_pixel)
	);
	// Strength 0 passes the input untouched
	assign new_pixel = (strength_reg == 3'h0) ? i_s_axis_tdata : filt_pixel;
	// Line buffers: no reset, contents refill within two lines
	always @(posedge i_clock) begin
		if (emit && lb_ok) begin
			lb1[cx] <= i_s_axis_tdata;
			lb2[cx] <= lb1[cx];
		end
	end

	// Window taps advance once per emitted pixel
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			left_reg <= 8'h00;
			center_reg <= 8'h00;
			up_reg <= 8'h00;
			down_reg <= 8'h00;
		end else if (emit) begin
			left_reg <= center_reg;
			center_reg <= right_tap;
			up_reg <= up_tap;
			down_reg <= i_s_axis_tdata;
		end
	end

	// Stream position state; full reset from the port reset
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			x_reg <= 13'h0000;
			y_reg <= 13'h0000;
			expect_sof_reg <= 1'b1;
			drop_line_reg <= 1'b0;
			drop_frame_reg <= 1'b0;
		end else if (!i_video_resetn) begin
			// Video reset is not frame aligned; tearing is expected
			x_reg <= 13'h0000;
			y_reg <= 13'h0000;
			expect_sof_reg <= 1'b1;
			drop_line_reg <= 1'b0;
			drop_frame_reg <= 1'b0;
		end else begin
			x_reg <= x_next;
			y_reg <= y_next;
			expect_sof_reg <= expect_sof_next;
			drop_line_reg <= drop_line_next;
			drop_frame_reg <= drop_frame_next;
		end
	end

	// Output stage with one skid entry so ready can come from a flop
	// One beat out per kept beat in, so rate and size follow the input
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_m_axis_tdata <= 8'h00;
			o_m_axis_tvalid <= 1'b0;
			o_m_axis_tuser <= 1'b0;
			o_m_axis_tlast <= 1'b0;
			skid_data_reg <= 8'h00;
			skid_user_reg <= 1'b0;
			skid_last_reg <= 1'b0;
			skid_valid_reg <= 1'b0;
			o_s_axis_tready <= 1'b0;
		end else if (!i_video_resetn) begin
			o_m_axis_tvalid <= 1'b0;
			skid_valid_reg <= 1'b0;
			o_s_axis_tready <= 1'b0;
		end else if (run) begin
			// Frozen while run is low, mid-frame or not
			if (!o_m_axis_tvalid || out_take) begin
				if (skid_valid_reg) begin
					o_m_axis_tdata <= skid_data_reg;
					o_m_axis_tuser <= skid_user_reg;
					o_m_axis_tlast <= skid_last_reg;
					o_m_axis_tvalid <= 1'b1;
					skid_valid_reg <= emit;
					skid_data_reg <= new_pixel;
					skid_user_reg <= e_sof;
					skid_last_reg <= e_eol;
					o_s_axis_tready <= !emit;
				end else begin
					o_m_axis_tvalid <= emit;
					o_m_axis_tdata <= new_pixel;
					o_m_axis_tuser <= e_sof;
					o_m_axis_tlast <= e_eol;
					o_s_axis_tready <= 1'b1;
				end
			end else if (emit) begin
				skid_valid_reg <= 1'b1;
				skid_data_reg <= new_pixel;
				skid_user_reg <= e_sof;
				skid_last_reg <= e_eol;
				o_s_axis_tready <= 1'b0;
			end else begin
				o_s_axis_tready <= !skid_valid_reg;
			end
		end
	end

	// Stall counter saturates at the timeout figure
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			stall_cnt_reg <= 8'h00;
		end else if (run) begin
			stall_cnt_reg <= 8'h00;
		end else if (!unreachable) begin
			stall_cnt_reg <= stall_cnt_reg + 8'h01;
		end
	end

	// Register writes; core registers refuse while unreachable
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= `EAD_CTRL_RST;
			size_reg <= `EAD_SIZE_RST;
			strength_reg <= `EAD_STRENGTH_RST;
			err_reg <= 4'h0;
		end else begin
			err_reg <= err_next;
			if (wr_en && (i_addr == `EAD_CTRL_OFF)) begin
				ctrl_reg <= {31'h0000_0000, i_wdata[`EAD_CTRL_RUN]};
			end
			if (wr_en && !unreachable && (i_addr == `EAD_SIZE_OFF)) begin
				size_reg <= {3'h0, i_wdata[28:16], 3'h0, i_wdata[12:0]};
			end
			// Values above four are ignored and the old strength kept
			if (wr_en && !unreachable && (i_addr == `EAD_STRENGTH_OFF) &&
				(i_wdata[31:0] <= {29'h0000_0000, `EAD_STRENGTH_MAX})) begin
				strength_reg <= i_wdata[2:0];
			end
		end
	end

	// Answers one cycle later, never waiting on the video side
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 32'h0000_0000;
			o_rd_resp <= `EAD_RESP_OKAY;
			o_wr_ack <= 1'b0;
			o_wr_resp <= `EAD_RESP_OKAY;
		end else begin
			o_wr_ack <= wr_en;
			o_wr_resp <= (wr_en && ead_is_core(i_addr) && unreachable) ? `EAD_RESP_TIMEOUT : `EAD_RESP_OKAY;
			o_rd_resp <= (rd_en && ead_is_core(i_addr) && unreachable) ? `EAD_RESP_TIMEOUT : `EAD_RESP_OKAY;
			o_rdata <= 32'h0000_0000;
			if (rd_en && !(ead_is_core(i_addr) && unreachable)) begin
				case (i_addr)
					`EAD_CTRL_OFF: o_rdata <= ctrl_reg;
					`EAD_STAT_OFF: o_rdata <= {27'h000_0000, drop_line_reg, drop_frame_reg,
						expect_sof_reg, unreachable, run};
					`EAD_ERR_OFF: o_rdata <= {28'h000_0000, err_reg};
					`EAD_SIZE_OFF: o_rdata <= size_reg;
					`EAD_STRENGTH_OFF: o_rdata <= {29'h0000_0000, strength_reg};
					default: o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // ead_core
`default_nettype wire

/* verilog/ead_kernel.v */
`timescale 1ns/1ps
`default_nettype none
module ead_kernel (
	input wire [7:0] i_left,
	input wire [7:0] i_right,
	input wire [7:0] i_up,
	input wire [7:0] i_down,
	input wire [7:0] i_center,
	input wire [2:0] i_strength,
	output wire [7:0] o_pixel
);

	// Centre weight per strength; neighbours share what is left of 16
	function [4:0] ead_center_weight;
		input [2:0] s;
		begin
			case (s)
				3'h1: ead_center_weight = 5'h0C;
				3'h2: ead_center_weight = 5'h08;
				3'h3: ead_center_weight = 5'h04;
				3'h4: ead_center_weight = 5'h00;
				default: ead_center_weight = 5'h10;
			endcase
		end
	endfunction

	// Absolute difference of two samples
	function [7:0] ead_absdiff;
		input [7:0] a;
		input [7:0] b;
		begin
			ead_absdiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	wire [4:0] wc;
	wire [4:0] wn;
	wire [9:0] sum4;
	wire [11:0] acc;
	wire [7:0] smooth;
	wire [8:0] grad;
	wire [4:0] gain;
	wire signed [9:0] diff;
	wire signed [15:0] prod;
	wire signed [15:0] res;

	// Fixed plus-shaped kernel, smoothing grows with strength
	assign wc = ead_center_weight(i_strength);
	assign wn = (5'h10 - wc) >> 2;
	assign sum4 = {2'h0, i_left} + {2'h0, i_right} + {2'h0, i_up} + {2'h0, i_down};
	assign acc = {4'h0, i_center} * {7'h00, wc} + {2'h0, sum4} * {7'h00, wn};
	assign smooth = acc[11:4];

	// Edge-adaptive gain: strong gradient pulls gain toward zero
	assign grad = {1'h0, ead_absdiff(i_left, i_right)} + {1'h0, ead_absdiff(i_up, i_down)};
	assign gain = (grad >= 9'h040) ? 5'h00 : (5'h10 - {1'h0, grad[5:2]});

	// Blend: centre plus gain times correction, result stays in range
	assign diff = $signed({2'h0, smooth}) - $signed({2'h0, i_center});
	assign prod = diff * $signed({1'h0, gain});
	assign res = $signed({8'h00, i_center}) + (prod >>> 4);
	assign o_pixel = res[7:0];
endmodule // ead_kernel
`default_nettype wire

/* verilog/ead_map.vh */
`ifndef EAD_MAP_VH
`define EAD_MAP_VH
// Register byte offsets
`define EAD_CTRL_OFF 12'h000
`define EAD_STAT_OFF 12'h004
`define EAD_ERR_OFF 12'h008
`define EAD_SIZE_OFF 12'h020
`define EAD_STRENGTH_OFF 12'h100
// Reset values and the strength limit
`define EAD_CTRL_RST 32'h0000_0001
`define EAD_SIZE_RST 32'h0020_0020
`define EAD_STRENGTH_RST 3'h0
`define EAD_STRENGTH_MAX 3'h4
// Field positions
`define EAD_CTRL_RUN 0
`define EAD_PIX_LSB 0
`define EAD_PIX_MSB 12
`define EAD_LIN_LSB 16
`define EAD_LIN_MSB 28
`define EAD_ERR_EOL_EARLY 0
`define EAD_ERR_EOL_LATE 1
`define EAD_ERR_SOF_EARLY 2
`define EAD_ERR_SOF_LATE 3
// Response codes
`define EAD_RESP_OKAY 2'h0
`define EAD_RESP_TIMEOUT 2'h2
// Timing and sizes
`define EAD_TIMEOUT_CYC 8'h80
`define EAD_MAX_PIX 13'h1E00
`define EAD_PIX_W 8
`endif
